// ===== verilog/bfp_port.sv
// device-side burst read and command write port of the flash
//
`timescale 1ns/1ps
module bfp_port (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // flash pins
    input wire logic bclk_in,
    input wire logic addr_valid_n_in,
    input wire logic chip_sel_n_in,
    input wire logic out_en_n_in,
    input wire logic wr_en_n_in,
    input wire logic hw_reset_n_in,
    input wire logic inv_flag_in,
    input wire logic prog_supply_hv_in,
    input wire logic [5:0] addr_hi_in,
    input wire bfp_pkg::bfp_word_t ad_in,
    output bfp_pkg::bfp_word_t ad_out,
    output logic ad_oe_n_out,
    output logic ready_out,
    output logic inv_flag_out,
    output logic inv_flag_oe_n_out,
    // array side
    output bfp_pkg::bfp_addr_t arr_addr_out,
    input wire bfp_pkg::bfp_word_t arr_data_in,
    input wire logic [1:0] bank_busy_in,
    input wire bfp_pkg::bfp_word_t status_in,
    // program requests, unprotect and burst mode flags
    output logic prog_req_out,
    output bfp_pkg::bfp_addr_t prog_addr_out,
    output bfp_pkg::bfp_word_t prog_data_out,
    output logic unprotect_out,
    output logic burst_mode_out
);
    import bfp_pkg::*;

    typedef struct packed {
        bfp_pins_t s1;
        bfp_pins_t s2;
        bfp_state_t state;
        logic burst_mode;
        bfp_addr_t addr;
        logic [3:0] wcnt;
        logic [1:0] stall;
        logic second;
        logic ld;
        logic valid;
        logic ps_en;
        logic [1:0] wait_code;
        logic id_mode;
        logic bypass;
        bfp_phase_t ph;
        bfp_word_t dq;
        logic dq_oe_n;
        logic rdy;
        logic inv;
        bfp_word_t prev;
        logic clk_prev;
        logic we_prev;
        logic avd_prev;
        logic [4:0] per_cnt;
        logic prog_req;
        bfp_addr_t prog_addr;
        bfp_word_t prog_data;
    } bfp_st_t;

    // sync flops reset to idle pin levels so no false edge follows reset
    localparam bfp_pins_t PIN_IDLE = '{
        avd_n: 1'b1,
        cs_n: 1'b1,
        oe_n: 1'b1,
        we_n: 1'b1,
        hwrst_n: 1'b1,
        default: '0
    };

    localparam bfp_st_t ST_RST = '{
        s1: PIN_IDLE,
        s2: PIN_IDLE,
        avd_prev: 1'b1,
        we_prev: 1'b1,
        state: BFP_IDLE,
        ph: PH_IDLE,
        wait_code: WAIT_CODE_RST,
        dq_oe_n: 1'b1,
        default: '0
    };

    bfp_st_t st_r;
    bfp_st_t st_nxt;
    bfp_pins_t pin;
    bfp_pins_t p;
    bfp_word_t enc_word;
    logic enc_inv;
    logic rise;
    logic we_fall;
    logic avd_rise;
    logic slow_now;
    logic bypass_eff;
    logic bnd;
    logic start;
    logic cmd_wr;
    bfp_addr_t next_addr;
    bfp_addr_t pin_addr;

    assign pin = '{
        bclk: bclk_in,
        avd_n: addr_valid_n_in,
        cs_n: chip_sel_n_in,
        oe_n: out_en_n_in,
        we_n: wr_en_n_in,
        hwrst_n: hw_reset_n_in,
        inv: inv_flag_in,
        hv: prog_supply_hv_in,
        ahi: addr_hi_in,
        ad: ad_in
    };
    assign p = st_r.s2;
    assign pin_addr = {p.ahi, p.ad};
    assign rise = p.bclk && !st_r.clk_prev;
    assign we_fall = !p.we_n && st_r.we_prev;
    assign avd_rise = p.avd_n && !st_r.avd_prev;
    assign slow_now = st_r.per_cnt >= 5'(SLOW_CYC);
    assign bypass_eff = st_r.bypass || p.hv;
    assign next_addr = (st_r.addr == ADDR_TOP) ? '0 : st_r.addr + 22'h000001;
    // boundary word: offset 3E of each 64-word block, top of range, or bank change
    assign bnd = (st_r.addr[5:0] == BND_OFS)
        || (st_r.addr == ADDR_TOP)
        || (next_addr[BANK_BIT] != st_r.addr[BANK_BIT]);
    assign start = !p.cs_n && rise && !p.avd_n;
    assign cmd_wr = we_fall && !p.cs_n && p.oe_n;

    bfp_ps_enc u_enc (
        .prev_in(st_r.prev),
        .word_in(arr_data_in),
        .en_in(st_r.ps_en),
        .bus_out(enc_word),
        .inv_out(enc_inv)
    );

    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = pin;
        st_nxt.s2 = st_r.s1;
        st_nxt.clk_prev = p.bclk;
        st_nxt.we_prev = p.we_n;
        st_nxt.avd_prev = p.avd_n;
        st_nxt.prog_req = 1'b0;
        st_nxt.ld = 1'b0;
        if (rise) begin
            st_nxt.per_cnt = '0;
        end else if (st_r.per_cnt != PER_MAX) begin
            st_nxt.per_cnt = st_r.per_cnt + 5'h01;
        end
        if (!p.hwrst_n) begin
            // reset pin ends everything and drops power saving
            st_nxt.state = BFP_IDLE;
            st_nxt.burst_mode = 1'b0;
            st_nxt.ps_en = 1'b0;
            st_nxt.wait_code = WAIT_CODE_RST;
            st_nxt.id_mode = 1'b0;
            st_nxt.bypass = 1'b0;
            st_nxt.ph = PH_IDLE;
            st_nxt.valid = 1'b0;
            st_nxt.inv = 1'b0;
        end else begin
            if (avd_rise && st_r.state == BFP_IDLE) begin
                st_nxt.addr = pin_addr;
            end
            if (cmd_wr) begin
                if (st_r.ph == PH_DATA) begin
                    st_nxt.prog_req = 1'b1;
                    st_nxt.prog_addr = st_r.addr;
                    st_nxt.prog_data = p.inv ? ~p.ad : p.ad;
                    st_nxt.ph = PH_IDLE;
                end else if (p.ad[7:0] == CMD_RESET) begin
                    // leaves id mode and drops a partial unlock or command sequence; a running burst goes on
                    st_nxt.id_mode = 1'b0;
                    st_nxt.ph = PH_IDLE;
                end else if (bypass_eff && st_r.ph == PH_IDLE && p.ad[7:0] == CMD_PGM) begin
                    st_nxt.ph = PH_DATA;
                end else if (st_r.bypass && st_r.ph == PH_IDLE && p.ad[7:0] == CMD_BYP_EXIT) begin
                    st_nxt.bypass = 1'b0;
                end else begin
                    unique case (st_r.ph)
                        PH_IDLE: begin
                            st_nxt.ph = (p.ad[7:0] == CMD_UNLK1) ? PH_UNLK : PH_IDLE;
                        end
                        PH_UNLK: begin
                            st_nxt.ph = (p.ad[7:0] == CMD_UNLK2) ? PH_CMD : PH_IDLE;
                        end
                        PH_CMD: begin
                            st_nxt.ph = PH_IDLE;
                            unique case (p.ad[7:0])
                                CMD_PGM: st_nxt.ph = PH_DATA;
                                CMD_WAIT: st_nxt.wait_code = p.ad[WAIT_ARG_LSB +: 2];
                                CMD_PS_EN: st_nxt.ps_en = 1'b1;
                                CMD_ID: st_nxt.id_mode = 1'b1;
                                CMD_BYP: st_nxt.bypass = 1'b1;
                                default: st_nxt.ph = PH_IDLE;
                            endcase
                        end
                        PH_DATA: st_nxt.ph = PH_IDLE;
                    endcase
                end
            end
            if (p.cs_n) begin
                // deselect ends the burst; array work continues outside
                st_nxt.state = BFP_IDLE;
                st_nxt.valid = 1'b0;
            end else if (start) begin
                // new address restarts the burst from any state
                st_nxt.burst_mode = 1'b1;
                st_nxt.addr = pin_addr;
                st_nxt.second = 1'b1;
                st_nxt.stall = '0;
                st_nxt.valid = 1'b0;
                st_nxt.inv = 1'b0;
                st_nxt.wcnt = WAIT_MIN + {2'h0, st_r.wait_code} - 4'h2 + {3'h0, st_r.ps_en};
                if (bank_busy_in[pin_addr[BANK_BIT]]) begin
                    st_nxt.state = BFP_STAT;
                end else begin
                    st_nxt.state = BFP_WAIT;
                end
            end else begin
                unique case (st_r.state)
                    BFP_IDLE: begin
                        st_nxt.valid = 1'b0;
                    end
                    BFP_WAIT: begin
                        if (rise) begin
                            if (st_r.wcnt == 4'h0) begin
                                st_nxt.ld = 1'b1;
                                st_nxt.state = BFP_DATA;
                            end else begin
                                st_nxt.wcnt = st_r.wcnt - 4'h1;
                            end
                        end
                    end
                    BFP_DATA: begin
                        if (st_r.ld) begin
                            st_nxt.valid = 1'b1;
                            st_nxt.dq = enc_word;
                            st_nxt.inv = enc_inv;
                            st_nxt.prev = enc_word;
                            st_nxt.second = 1'b0;
                            st_nxt.stall = (bnd ? BND_STALL : 2'h0)
                                + {1'b0, st_r.second && st_r.ps_en};
                        end else if (rise) begin
                            if (st_r.stall != 2'h0) begin
                                st_nxt.stall = st_r.stall - 2'h1;
                                st_nxt.valid = 1'b0;
                            end else if (slow_now && st_r.valid) begin
                                // one ready-low edge per slow edge, then the next edge advances
                                st_nxt.valid = 1'b0;
                            end else if (bank_busy_in[next_addr[BANK_BIT]]
                                && next_addr[BANK_BIT] != st_r.addr[BANK_BIT]) begin
                                st_nxt.state = BFP_STAT;
                                st_nxt.valid = 1'b0;
                            end else begin
                                st_nxt.addr = next_addr;
                                st_nxt.ld = 1'b1;
                                st_nxt.valid = 1'b0;
                            end
                        end
                    end
                    BFP_STAT: begin
                        // clock is ignored here; only a new address, deselect or the reset pin leaves
                        st_nxt.valid = 1'b0;
                    end
                endcase
            end
        end
        // bus drivers: off when deselected, reset, writing or out_en_n high
        st_nxt.dq_oe_n = p.cs_n || p.oe_n || !p.we_n || !p.hwrst_n;
        st_nxt.rdy = st_nxt.valid && !p.oe_n && !p.cs_n;
        if (st_nxt.state == BFP_IDLE) begin
            st_nxt.inv = 1'b0;
            if (st_r.id_mode) begin
                st_nxt.dq = {8'h00, st_r.addr[0] ? ID_PART : ID_MAKER};
            end else if (bank_busy_in[st_r.addr[BANK_BIT]]) begin
                st_nxt.dq = status_in;
            end else begin
                st_nxt.dq = arr_data_in;
            end
        end else if (st_nxt.state == BFP_STAT) begin
            st_nxt.inv = 1'b0;
            st_nxt.dq = status_in;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign ad_out = st_r.dq;
    assign ad_oe_n_out = st_r.dq_oe_n;
    assign ready_out = st_r.rdy;
    assign inv_flag_out = st_r.inv;
    assign inv_flag_oe_n_out = st_r.dq_oe_n;
    assign arr_addr_out = st_r.addr;
    assign prog_req_out = st_r.prog_req;
    assign prog_addr_out = st_r.prog_addr;
    assign prog_data_out = st_r.prog_data;
    assign unprotect_out = st_r.s2.hv;
    assign burst_mode_out = st_r.burst_mode;

    ps_sticky_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        st_r.ps_en && p.hwrst_n |=> st_r.ps_en)
        else $error("power saving dropped without reset");

    ps_enable_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        !st_r.ps_en && !(cmd_wr && st_r.ph == PH_CMD) |=> !st_r.ps_en)
        else $error("power saving enabled without command");

    deselect_hiz_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        p.cs_n |=> ad_oe_n_out && !ready_out)
        else $error("bus driven while deselected");

    inv_needs_ps_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        inv_flag_out |-> st_r.ps_en && st_r.state == BFP_DATA)
        else $error("inverted word outside power-saving burst");

    boundary_stall_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        st_r.state == BFP_DATA && st_r.ld && !p.cs_n && !start && p.hwrst_n
        && st_r.addr[5:0] == BND_OFS |=> st_r.stall >= BND_STALL)
        else $error("no stall after boundary word");

    wrap_zero_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        st_r.state == BFP_DATA && st_r.addr == ADDR_TOP
        |=> st_r.addr == ADDR_TOP || st_r.addr == '0 || st_r.state != BFP_DATA)
        else $error("address moved past top");

    ready_oe_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        p.oe_n |=> !ready_out)
        else $error("ready high with out_en_n high");

    hw_reset_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        !p.hwrst_n |=> st_r.wait_code == WAIT_CODE_RST && !st_r.ps_en && st_r.state == BFP_IDLE)
        else $error("reset pin did not restore defaults");

    stall_ready_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        st_r.state == BFP_DATA && rise && st_r.stall != 2'h0 && !st_r.ld && !start && !p.cs_n
        && p.hwrst_n |=> !st_r.valid ##1 !ready_out)
        else $error("ready high during stall");

    status_bank_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        st_r.state == BFP_STAT && !p.cs_n && p.hwrst_n && !start |=> st_r.state == BFP_STAT)
        else $error("status state left without new address");

endmodule : bfp_port

// ===== verilog/bfp_pkg.sv
// constants, types and carriers of the burst flash read/write port
package bfp_pkg;
    localparam int CLK_KHZ = 100000;
    localparam int SLOW_KHZ = 6000;
    localparam int SLOW_CYC = CLK_KHZ / SLOW_KHZ;
    localparam logic [21:0] ADDR_TOP = 22'h03FFFF;
    localparam logic [5:0] BND_OFS = 6'h3E;
    localparam int BANK_BIT = 21;
    localparam logic [1:0] BND_STALL = 2'h2;
    localparam logic [3:0] WAIT_MIN = 4'h4;
    localparam logic [1:0] WAIT_CODE_RST = 2'h3;
    localparam int WAIT_ARG_LSB = 8;
    localparam logic [4:0] PER_MAX = 5'h1F;
    // command opcodes on the low data byte
    localparam logic [7:0] CMD_UNLK1 = 8'hAA;
    localparam logic [7:0] CMD_UNLK2 = 8'h55;
    localparam logic [7:0] CMD_PGM = 8'hA0;
    localparam logic [7:0] CMD_WAIT = 8'hC0;
    localparam logic [7:0] CMD_PS_EN = 8'h70;
    localparam logic [7:0] CMD_ID = 8'h90;
    localparam logic [7:0] CMD_BYP = 8'h20;
    localparam logic [7:0] CMD_BYP_EXIT = 8'h00;
    localparam logic [7:0] CMD_RESET = 8'hF0;
    // arbitrary identification values
    localparam logic [7:0] ID_MAKER = 8'h5A;
    localparam logic [7:0] ID_PART = 8'h3C;
    typedef logic [15:0] bfp_word_t;
    typedef logic [21:0] bfp_addr_t;
    typedef enum logic [1:0] {
        BFP_IDLE = 2'b00,
        BFP_WAIT = 2'b01,
        BFP_DATA = 2'b11,
        BFP_STAT = 2'b10
    } bfp_state_t;
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_UNLK = 2'b01,
        PH_CMD = 2'b11,
        PH_DATA = 2'b10
    } bfp_phase_t;
    typedef struct packed {
        logic bclk;
        logic avd_n;
        logic cs_n;
        logic oe_n;
        logic we_n;
        logic hwrst_n;
        logic inv;
        logic hv;
        logic [5:0] ahi;
        bfp_word_t ad;
    } bfp_pins_t;
endpackage : bfp_pkg

// ===== verilog/bfp_ps_enc.sv
// power-saving word encoder: inverts when too many bus bits would toggle
`timescale 1ns/1ps
module bfp_ps_enc (
    // words
    input wire bfp_pkg::bfp_word_t prev_in,
    input wire bfp_pkg::bfp_word_t word_in,
    input wire logic en_in,
    // encoded
    output bfp_pkg::bfp_word_t bus_out,
    output logic inv_out
);
    import bfp_pkg::*;
    logic [4:0] flips;
    always_comb begin
        flips = 5'h00;
        for (int i = 0; i < 16; i++) begin
            flips = flips + {4'h0, prev_in[i] ^ word_in[i]};
        end
        inv_out = en_in && (flips >= 5'h09);
        bus_out = inv_out ? ~word_in : word_in;
    end
endmodule : bfp_ps_enc

// ===== sim/bfp_host.sv
// host memory controller model: drives strobes and burst clock, captures burst words
`timescale 1ns/1ps
module bfp_host (
    // clock
    input wire logic clock_in,
    // device answers
    input wire logic ready_in,
    input wire bfp_pkg::bfp_word_t ad_in,
    input wire logic inv_in,
    // pins
    output bfp_pkg::bfp_pins_t pins_out
);
    import bfp_pkg::*;
    bfp_word_t words[$];
    logic invs[$];
    int edges[$];
    initial begin
        pins_out = '{avd_n: 1'b1, cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, hwrst_n: 1'b1, default: '0};
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
    endtask : tick
    // bclk stays low through every async cycle so no burst starts by accident
    task automatic wr(input bfp_addr_t a, input bfp_word_t d, input logic inv);
        pins_out.cs_n <= 1'b0;
        pins_out.avd_n <= 1'b0;
        pins_out.ahi <= a[21:16];
        pins_out.ad <= a[15:0];
        tick(4);
        pins_out.avd_n <= 1'b1;
        tick(4);
        pins_out.ad <= d;
        pins_out.inv <= inv;
        pins_out.we_n <= 1'b0;
        tick(4);
        pins_out.we_n <= 1'b1;
        tick(4);
        pins_out.cs_n <= 1'b1;
        pins_out.ad <= ~d;
        pins_out.inv <= ~inv;
        tick(4);
    endtask : wr
    task automatic cmd(input bfp_word_t op);
        wr(22'h000000, {8'h00, CMD_UNLK1}, 1'b0);
        wr(22'h000000, {8'h00, CMD_UNLK2}, 1'b0);
        wr(22'h000000, op, 1'b0);
    endtask : cmd
    task automatic aread(input bfp_addr_t a, output bfp_word_t w);
        pins_out.cs_n <= 1'b0;
        pins_out.avd_n <= 1'b0;
        pins_out.ahi <= a[21:16];
        pins_out.ad <= a[15:0];
        tick(4);
        // address held past the avd rise, where the device latches it
        pins_out.avd_n <= 1'b1;
        tick(4);
        pins_out.ad <= ~a[15:0];
        pins_out.oe_n <= 1'b0;
        tick(8);
        @(negedge clock_in);
        w = ad_in;
        @(posedge clock_in);
        pins_out.oe_n <= 1'b1;
        pins_out.cs_n <= 1'b1;
        tick(4);
    endtask : aread
    // words taken only while ready is high; a low ready holds the pointer
    task automatic burst(input bfp_addr_t a, input int n, input int half);
        int e;
        e = 0;
        words.delete();
        invs.delete();
        edges.delete();
        pins_out.cs_n <= 1'b0;
        pins_out.avd_n <= 1'b0;
        pins_out.ahi <= a[21:16];
        pins_out.ad <= a[15:0];
        tick(2);
        while (words.size() < n && e < 40) begin
            pins_out.bclk <= 1'b1;
            e++;
            tick(2);
            if (e == 1) begin
                pins_out.avd_n <= 1'b1;
                pins_out.ad <= ~a[15:0];
                pins_out.oe_n <= 1'b0;
            end
            tick(half - 3);
            @(negedge clock_in);
            if (ready_in === 1'b1) begin
                words.push_back(ad_in);
                invs.push_back(inv_in);
                edges.push_back(e);
            end
            @(posedge clock_in);
            pins_out.bclk <= 1'b0;
            tick(half);
        end
        pins_out.cs_n <= 1'b1;
        pins_out.oe_n <= 1'b1;
        tick(6);
    endtask : burst
    task automatic hwrst();
        pins_out.hwrst_n <= 1'b0;
        tick(6);
        pins_out.hwrst_n <= 1'b1;
        tick(6);
    endtask : hwrst
    task automatic supply(input logic v);
        pins_out.hv <= v;
        tick(6);
    endtask : supply
endmodule : bfp_host

// ===== sim/testbench.sv
// self-checking bench of the burst flash port against a host model and array model
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("[ERR] %s exp %0h got %0h", nm, exp, got); end end
module testbench;
    import bfp_pkg::*;
    logic clock_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [1:0] bank_busy = 2'h0;
    bfp_pins_t pins;
    bfp_word_t ad_bus, ad_out, arr_data, prog_data, w;
    bfp_addr_t arr_addr, prog_addr;
    logic ad_oe_n, ready, inv_out, inv_oe_n, prog_req, unprot, burst_on, inv_bus;
    int mismatches = 0;
    int checks = 0;
    int cyc = 0;
    int n_prog = 0;
    int ninv = 0;
    function automatic bfp_word_t dat(input bfp_addr_t a);
        return {a[7:0], a[7:0]} ^ {16{a[0]}};
    endfunction : dat
    always #5 clock_in = ~clock_in;
    // bus wire: device drives when its enable is low
    assign ad_bus = ad_oe_n ? pins.ad : ad_out;
    assign inv_bus = inv_oe_n ? pins.inv : inv_out;
    // array model answers in the same cycle as the address
    assign arr_data = dat(arr_addr);
    always @(posedge clock_in) if (prog_req === 1'b1) n_prog <= n_prog + 1;
    bfp_host u_host (.clock_in(clock_in), .ready_in(ready), .ad_in(ad_bus), .inv_in(inv_bus), .pins_out(pins));
    bfp_port u_dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .bclk_in(pins.bclk), .addr_valid_n_in(pins.avd_n),
        .chip_sel_n_in(pins.cs_n), .out_en_n_in(pins.oe_n), .wr_en_n_in(pins.we_n), .hw_reset_n_in(pins.hwrst_n),
        .inv_flag_in(inv_bus), .prog_supply_hv_in(pins.hv), .addr_hi_in(pins.ahi), .ad_in(ad_bus),
        .ad_out(ad_out), .ad_oe_n_out(ad_oe_n), .ready_out(ready), .inv_flag_out(inv_out),
        .inv_flag_oe_n_out(inv_oe_n), .arr_addr_out(arr_addr), .arr_data_in(arr_data), .bank_busy_in(bank_busy),
        .status_in(16'hC0DE), .prog_req_out(prog_req), .prog_addr_out(prog_addr), .prog_data_out(prog_data),
        .unprotect_out(unprot), .burst_mode_out(burst_on));
    task automatic end_sim();
        if (mismatches == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_sim
    task automatic chk_burst(input bfp_addr_t a, input int n, input logic ps);
        bfp_addr_t x;
        `CHK("count", n, u_host.words.size())
        for (int k = 0; k < n; k++) begin
            x = bfp_addr_t'((int'(a) + k) % (int'(ADDR_TOP) + 1));
            w = u_host.words[k] ^ {16{u_host.invs[k]}};
            `CHK("word", dat(x), w)
            if (!ps) `CHK("inv", 1'b0, u_host.invs[k])
            if (ps && k > 0) `CHK("toggles", 1'b1, $countones(u_host.words[k - 1] ^ u_host.words[k]) <= 8)
        end
    endtask : chk_burst
    always @(posedge clock_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            end_sim();
        end
    end
    initial begin
        repeat (12) @(posedge clock_in);
        `CHK("oe_n rst", 1'b1, ad_oe_n)
        `CHK("ready rst", 1'b0, ready)
        `CHK("burst rst", 1'b0, burst_on)
        rst_n_in <= 1'b1;
        u_host.tick(6);
        u_host.burst(22'h000010, 3, 8);
        chk_burst(22'h000010, 3, 1'b0);
        `CHK("first edge", 7, u_host.edges[0])
        `CHK("next edge", 8, u_host.edges[1])
        `CHK("burst on", 1'b1, burst_on)
        `CHK("released", 1'b1, ad_oe_n)
        for (int c = 0; c < 4; c++) begin
            u_host.cmd({6'h00, c[1:0], CMD_WAIT});
            u_host.burst(22'h00003C, 4, 8);
            chk_burst(22'h00003C, 4, 1'b0);
            `CHK("wait edge", 4 + c, u_host.edges[0])
            `CHK("stall gap", 3, u_host.edges[3] - u_host.edges[2])
        end
        u_host.burst(22'h03FFFE, 3, 8);
        chk_burst(22'h03FFFE, 3, 1'b0);
        `CHK("top gap", 3, u_host.edges[2] - u_host.edges[1])
        // slow burst clock, period of 20 system clocks
        u_host.burst(22'h000020, 3, 10);
        chk_burst(22'h000020, 3, 1'b0);
        `CHK("slow gap", 2, u_host.edges[2] - u_host.edges[1])
        u_host.cmd({8'h00, CMD_ID});
        u_host.aread(22'h000000, w);
        `CHK("maker", ID_MAKER, w[7:0])
        u_host.aread(22'h000001, w);
        `CHK("part", ID_PART, w[7:0])
        u_host.hwrst();
        u_host.cmd({8'h00, CMD_PS_EN});
        u_host.burst(22'h000040, 6, 8);
        chk_burst(22'h000040, 6, 1'b1);
        `CHK("ps first", 8, u_host.edges[0])
        `CHK("ps second", 2, u_host.edges[1] - u_host.edges[0])
        foreach (u_host.invs[k]) ninv += (u_host.invs[k] === 1'b1) ? 1 : 0;
        `CHK("ps inverted", 1'b1, ninv > 0)
        // software reset must leave power saving on
        u_host.wr(22'h000000, {8'h00, CMD_RESET}, 1'b0);
        u_host.burst(22'h000040, 2, 8);
        `CHK("ps kept", 8, u_host.edges[0])
        u_host.hwrst();
        u_host.burst(22'h000040, 2, 8);
        chk_burst(22'h000040, 2, 1'b0);
        `CHK("ps cleared", 7, u_host.edges[0])
        u_host.cmd({8'h00, CMD_PGM});
        u_host.wr(22'h012345, 16'h5A3C, 1'b1);
        `CHK("prog count", 1, n_prog)
        `CHK("prog addr", 22'h012345, prog_addr)
        `CHK("prog data", 16'hA5C3, prog_data)
        u_host.supply(1'b1);
        `CHK("unprotect", 1'b1, unprot)
        u_host.wr(22'h000000, {8'h00, CMD_PGM}, 1'b0);
        u_host.wr(22'h000077, 16'h1234, 1'b0);
        `CHK("byp count", 2, n_prog)
        `CHK("byp data", 16'h1234, prog_data)
        u_host.supply(1'b0);
        `CHK("protect", 1'b0, unprot)
        // bank crossing with the far bank idle, then busy
        u_host.burst(22'h1FFFFE, 3, 8);
        chk_burst(22'h1FFFFE, 3, 1'b0);
        `CHK("bank gap", 3, u_host.edges[2] - u_host.edges[1])
        bank_busy <= 2'h2;
        u_host.burst(22'h1FFFFE, 3, 8);
        chk_burst(22'h1FFFFE, 2, 1'b0);
        u_host.aread(22'h200000, w);
        `CHK("status", 16'hC0DE, w)
        u_host.aread(22'h000005, w);
        `CHK("other bank", dat(22'h000005), w)
        end_sim();
    end
endmodule : testbench
